// ==== spi_mem_pkg.sv ====
// shared constants and types for the serial memory front end and its master
package spi_mem_pkg;
    localparam int unsigned   ARRAY_DEPTH_LARGE = 2048;
    localparam int unsigned   ARRAY_DEPTH_SMALL = 1024;
    localparam int unsigned   ADDR_W            = 11;
    localparam int unsigned   BYTE_W            = 8;
    localparam int unsigned   BIT_CNT_W         = 3;
    localparam logic [2:0]    BIT_LAST          = 3'h7;
    localparam logic [2:0]    BIT_FIRST         = 3'h0;
    localparam logic [7:0]    OP_WREN           = 8'h06;
    localparam logic [7:0]    OP_WRDI           = 8'h04;
    localparam logic [7:0]    OP_RDSR           = 8'h05;
    localparam logic [7:0]    OP_WRSR           = 8'h01;
    localparam logic [7:0]    OP_READ           = 8'h03;
    localparam logic [7:0]    OP_WRITE          = 8'h02;
    localparam int unsigned   SR_PROT_LO        = 2;
    localparam int unsigned   SR_PROT_HI        = 3;
    localparam int unsigned   SR_WEL            = 1;
    localparam logic [7:0]    SR_RESET          = 8'h00;
    localparam logic [7:0]    SR_PROT_MASK      = 8'h0C;
    // master clock divider: last divider count; link clock half period is DIV_HALF+1 core cycles
    localparam logic [3:0]    DIV_HALF          = 4'h4;

    typedef enum logic [2:0] {
        ST_WAIT_EDGE, ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_STATUS_WR, ST_IGNORE
    } dev_state_type;

    typedef enum logic [2:0] {
        MS_IDLE, MS_SELECT, MS_LOW, MS_HIGH, MS_END
    } mst_state_type;
endpackage : spi_mem_pkg

// ==== spi_mem_if.sv ====
// link wires between the serial memory master and the memory device
`timescale 1ns/1ps
interface spi_mem_if;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic cs_n;
    logic hold_n;
    logic wp_n;

    modport master (output sclk, output mosi, output cs_n, output hold_n, output wp_n,
                    input miso, input miso_oe);
    modport device (input sclk, input mosi, input cs_n, input hold_n, input wp_n,
                    output miso, output miso_oe);
endinterface : spi_mem_if

// ==== spi_mem_device.sv ====
// serial memory device end: spi slave front end with byte array and status
// Contract
// - array of 2048 or 1024 bytes
// - input bit captured on clock rise
// - output changes only after clock fall
// - select high means output tri-stated
// - active when selected, standby when idle
// - need select falling edge after power-up; a select held low through reset is taken as one
// - pause freezes transfer, output tri-stated
// - master pauses only while selected
// - lock pin freezes protect size bits
// - master keeps lock pin steady during writes
// - inbound bits most significant first
// - outbound bytes most significant first
// - first bit on first rise after select
// - read data starts after following fall
// - both positive clock modes work
// - idle clock level either 0 or 1
// - master selects one device at once
// - clock and select never rise together
// - pause enters and leaves with clock low
// - deselect during pause resets interface
// - unknown opcode ignored until next select
// - select rises between last and next rise
`timescale 1ns/1ps
module spi_mem_device
    import spi_mem_pkg::*;
#(
    parameter int unsigned DEPTH = ARRAY_DEPTH_LARGE
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    spi_mem_if.device       link,
    output logic            active_power,
    output logic            write_busy,
    output logic [7:0]      status_out
);
    // two-stage synchronisers for every link pin
    logic [1:0] sclk_s, mosi_s, cs_s, hold_s, wp_s;
    logic       sclk_d;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 2'h0;
            mosi_s <= 2'h0;
            cs_s   <= 2'h3;
            hold_s <= 2'h3;
            wp_s   <= 2'h3;
            sclk_d <= 1'b0;
        end else if (clk_en) begin
            sclk_s <= {sclk_s[0], link.sclk};
            mosi_s <= {mosi_s[0], link.mosi};
            cs_s   <= {cs_s[0], link.cs_n};
            hold_s <= {hold_s[0], link.hold_n};
            wp_s   <= {wp_s[0], link.wp_n};
            sclk_d <= sclk_s[1];
        end
    end

    logic sclk_v, mosi_v, cs_v, hold_v, wp_v;
    assign sclk_v = sclk_s[1];
    assign mosi_v = mosi_s[1];
    assign cs_v   = cs_s[1];
    assign hold_v = hold_s[1];
    assign wp_v   = wp_s[1];

    logic cs_d, pause_r, armed_r;
    logic rise, fall, cs_fall;
    assign rise    = sclk_v & ~sclk_d;
    assign fall    = ~sclk_v & sclk_d;

    // select edge history; starts high, so a select held low at power-up counts as an edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d <= 1'b1;
        end else if (clk_en) begin
            cs_d <= cs_v;
        end
    end
    assign cs_fall = cs_d & ~cs_v;

    // armed only by a seen falling edge of select
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall)
                armed_r <= 1'b1;
            else if (cs_v)
                armed_r <= 1'b0;
        end
    end

    // pause condition follows hold only while clock is low and selected
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_r <= 1'b0;
        end else if (clk_en) begin
            if (cs_v)
                pause_r <= 1'b0;
            else if (!sclk_v)
                pause_r <= ~hold_v;
        end
    end

    logic go;
    assign go = armed_r & ~cs_v & ~pause_r;

    // memory array and transfer state
    logic [7:0]          mem [0:DEPTH-1];
    logic [7:0]          status_r;
    logic [7:0]          shift_r;
    logic [7:0]          out_r;
    logic [2:0]          bit_r;
    logic [ADDR_W-1:0]   addr_r;
    logic [7:0]          opcode_r;
    logic                out_en_r;
    logic                wr_pend_r;
    dev_state_type       state_r;
    logic [7:0]          byte_in;
    logic                byte_done;

    assign byte_in   = {shift_r[6:0], mosi_v};
    assign byte_done = go & rise & (bit_r == BIT_LAST);

    // protection check on write address
    function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        logic [1:0] top;
        top = (DEPTH == ARRAY_DEPTH_LARGE) ? a[ADDR_W-1 -: 2] : a[ADDR_W-2 -: 2];
        case (bp)
            2'h1:    prot_hit = (top == 2'h3);
            2'h2:    prot_hit = top[1];
            2'h3:    prot_hit = 1'b1;
            default: prot_hit = 1'b0;
        endcase
    endfunction : prot_hit

    // bit counter and shifter, cleared on deselect
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
            bit_r   <= BIT_FIRST;
        end else if (clk_en) begin
            if (cs_v) begin
                shift_r <= 8'h00;
                bit_r   <= BIT_FIRST;
            end else if (go && rise) begin
                shift_r <= byte_in;
                bit_r   <= bit_r + 3'h1;
            end
        end
    end

    // protocol sequencing per completed byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_WAIT_EDGE;
            opcode_r  <= 8'h00;
            addr_r    <= '0;
            status_r  <= SR_RESET;
            wr_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (cs_v) begin
                // completed write sequences drop write enable on deselect
                if (wr_pend_r && bit_r == BIT_FIRST)
                    status_r[SR_WEL] <= 1'b0;
                wr_pend_r <= 1'b0;
                state_r   <= ST_WAIT_EDGE;
            end else if (state_r == ST_WAIT_EDGE && go) begin
                state_r <= ST_OPCODE;
            end else if (byte_done) begin
                case (state_r)
                    ST_OPCODE: begin
                        opcode_r <= byte_in;
                        case (byte_in)
                            OP_WREN:  begin status_r[SR_WEL] <= 1'b1; state_r <= ST_IGNORE; end
                            OP_WRDI:  begin status_r[SR_WEL] <= 1'b0; state_r <= ST_IGNORE; end
                            OP_RDSR:  state_r <= ST_DATA;
                            OP_WRSR:  state_r <= ST_STATUS_WR;
                            OP_READ,
                            OP_WRITE: state_r <= ST_ADDR_HI;
                            default:  state_r <= ST_IGNORE;
                        endcase
                    end
                    ST_ADDR_HI: begin
                        addr_r[ADDR_W-1:BYTE_W] <= byte_in[ADDR_W-BYTE_W-1:0];
                        state_r <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        addr_r[BYTE_W-1:0] <= byte_in;
                        state_r <= ST_DATA;
                    end
                    ST_DATA: begin
                        if (opcode_r == OP_WRITE && status_r[SR_WEL]) begin
                            wr_pend_r <= 1'b1;
                        end
                        addr_r <= addr_r + 1'b1;
                    end
                    ST_STATUS_WR: begin
                        // lock pin low freezes the protect size bits
                        if (status_r[SR_WEL] && wp_v)
                            status_r <= (status_r & ~SR_PROT_MASK) | (byte_in & SR_PROT_MASK);
                        status_r[SR_WEL] <= 1'b0;
                        state_r <= ST_IGNORE;
                    end
                    default: state_r <= ST_IGNORE;
                endcase
            end
        end
    end

    // array write per data byte; a trailing partial byte is never stored
    always_ff @(posedge core_clk) begin
        if (clk_en && byte_done && state_r == ST_DATA && opcode_r == OP_WRITE
            && status_r[SR_WEL] && !prot_hit(addr_r, status_r[SR_PROT_HI:SR_PROT_LO]))
            mem[addr_r[$clog2(DEPTH)-1:0]] <= byte_in;
    end

    // output shifter: loads on the fall after a byte, shifts on later falls
    logic [7:0] rd_byte;
    logic       load_pend_r;
    assign rd_byte = (opcode_r == OP_RDSR) ? status_r : mem[addr_r[$clog2(DEPTH)-1:0]];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r       <= 8'h00;
            out_en_r    <= 1'b0;
            load_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (cs_v) begin
                out_en_r    <= 1'b0;
                load_pend_r <= 1'b0;
            end else begin
                if (byte_done && (state_r == ST_ADDR_LO || (state_r == ST_OPCODE
                    && byte_in == OP_RDSR) || (state_r == ST_DATA && opcode_r != OP_WRITE)))
                    load_pend_r <= 1'b1;
                if (go && fall) begin
                    if (load_pend_r) begin
                        out_r       <= rd_byte;
                        out_en_r    <= 1'b1;
                        load_pend_r <= 1'b0;
                    end else begin
                        out_r <= {out_r[6:0], 1'b0};
                    end
                end
            end
        end
    end

    assign link.miso    = out_r[BYTE_W-1];
    assign link.miso_oe = out_en_r & ~cs_v & ~pause_r;
    assign active_power = ~cs_v | wr_pend_r;
    assign write_busy   = wr_pend_r;
    assign status_out   = status_r;
endmodule : spi_mem_device

// ==== spi_mem_master.sv ====
// serial memory master end: drives clock, select, pause and lock pins
`timescale 1ns/1ps
module spi_mem_master
    import spi_mem_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    spi_mem_if.master       link,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [7:0] req_byte,
    input  wire logic       req_last,
    input  wire logic       idle_high,
    input  wire logic       pause_req,
    input  wire logic       lock_level,
    output logic [7:0]      rsp_byte,
    output logic            rsp_valid
);
    mst_state_type state_r;
    logic [3:0]    div_r;
    logic [2:0]    bit_r;
    logic [7:0]    tx_r, rx_r;
    logic          last_r, sclk_r, cs_r, hold_r, wp_r, mode_r, rsp_valid_r;
    logic [1:0]    miso_s;

    // miso comes from the device's domain view; resynchronise it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            miso_s <= 2'h0;
        else if (clk_en)
            miso_s <= {miso_s[0], link.miso};
    end

    logic tick;
    assign tick = (div_r == DIV_HALF);

    // pause only while selected, with the clock low; never on a tick edge, since that
    // edge may raise the clock and the pause would then start with the clock high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            hold_r <= 1'b1;
        else if (clk_en && (state_r == MS_LOW || state_r == MS_SELECT) && !sclk_r && !tick)
            hold_r <= ~pause_req;
    end

    // transfer sequencer: idle clock parked at mode level, msb first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= MS_IDLE;
            div_r       <= 4'h0;
            bit_r       <= BIT_FIRST;
            tx_r        <= 8'h00;
            rx_r        <= 8'h00;
            last_r      <= 1'b0;
            sclk_r      <= 1'b0;
            cs_r        <= 1'b1;
            wp_r        <= 1'b1;
            mode_r      <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else if (clk_en) begin
            rsp_valid_r <= 1'b0;
            div_r       <= tick ? 4'h0 : div_r + 4'h1;
            case (state_r)
                MS_IDLE: begin
                    sclk_r <= mode_r;
                    if (req_valid) begin
                        mode_r  <= idle_high;
                        wp_r    <= lock_level;
                        tx_r    <= req_byte;
                        last_r  <= req_last;
                        cs_r    <= 1'b0;
                        bit_r   <= BIT_FIRST;
                        div_r   <= 4'h0;
                        state_r <= MS_SELECT;
                    end
                end
                MS_SELECT: if (tick && hold_r) begin
                    sclk_r  <= 1'b0;
                    state_r <= MS_LOW;
                end
                MS_LOW: if (tick && hold_r) begin
                    sclk_r  <= 1'b1;
                    state_r <= MS_HIGH;
                end
                // stall with the clock high when the next byte is late, so no bit is lost
                MS_HIGH: if (tick && (bit_r != BIT_LAST || last_r || req_valid)) begin
                    // sample at the end of the high phase: the device output lags the fall
                    // by its sync flops plus ours, too late for the rising edge itself
                    rx_r <= {rx_r[6:0], miso_s[1]};
                    if (bit_r == BIT_LAST) begin
                        rsp_valid_r <= 1'b1;
                        if (last_r) begin
                            cs_r    <= 1'b1;
                            state_r <= MS_END;
                        end else if (req_valid) begin
                            tx_r    <= req_byte;
                            last_r  <= req_last;
                            sclk_r  <= 1'b0;
                            state_r <= MS_LOW;
                        end
                    end else begin
                        tx_r    <= {tx_r[6:0], 1'b0};
                        sclk_r  <= 1'b0;
                        state_r <= MS_LOW;
                    end
                    if (bit_r != BIT_LAST || !last_r)
                        bit_r <= bit_r + 3'h1;
                end
                MS_END: if (tick) begin
                    sclk_r  <= mode_r;
                    state_r <= MS_IDLE;
                end
                default: state_r <= MS_IDLE;
            endcase
        end
    end

    assign req_ready   = (state_r == MS_IDLE) ||
                         (state_r == MS_HIGH && tick && bit_r == BIT_LAST && !last_r);
    assign rsp_byte    = rx_r;
    assign rsp_valid   = rsp_valid_r;
    assign link.sclk   = sclk_r;
    assign link.mosi   = tx_r[BYTE_W-1];
    assign link.cs_n   = cs_r;
    assign link.hold_n = hold_r;
    assign link.wp_n   = wp_r;
endmodule : spi_mem_master

// ==== spi_link_assertions.sv ====
// concurrent checks on the serial link between memory master and memory device
`timescale 1ns/1ps
module spi_link_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic wp_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // link pins pass two sync flops in the device, so let them settle first
    sequence s_desel_settled;
        cs_n [*4];
    endsequence
    sequence s_pause_settled;
        (!hold_n && !cs_n) [*4];
    endsequence

    // output enable and data line against select, pause and clock
    a_deselect_no_drive: assert property (s_desel_settled |-> !miso_oe)
        else $error("data out driven while deselected");
    a_pause_no_drive: assert property (s_pause_settled |-> !miso_oe)
        else $error("data out driven while paused");
    a_out_after_fall: assert property ((miso_oe && $past(miso_oe) && $changed(miso))
        |-> (!sclk && !$past(sclk)))
        else $error("data out changed outside clock low phase");
    a_drive_needs_select: assert property ($rose(miso_oe) |-> (!cs_n && hold_n))
        else $error("data out enabled without select");
    // master side duties on pause, lock, select and data in
    a_pause_when_selected: assert property ($fell(hold_n) |-> !cs_n)
        else $error("pause entered while deselected");
    a_pause_clock_low: assert property (($fell(hold_n) || $rose(hold_n)) |-> !sclk)
        else $error("pause edge with clock high");
    a_lock_steady: assert property ((!cs_n && !$past(cs_n)) |-> $stable(wp_n))
        else $error("lock pin moved inside a frame");
    a_no_joint_rise: assert property ($rose(cs_n) |-> !$rose(sclk))
        else $error("select and clock rose together");
    a_data_in_steady: assert property (($rose(sclk) && !cs_n) |-> $stable(mosi))
        else $error("data in moved at clock rise");

    c_pause_seen: cover property (s_pause_settled);
endmodule : spi_link_assertions

// ==== spi_eeprom_serial_front_end_test.sv ====
// self-checking bench: memory master and memory device joined over the link
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_test;
    import spi_mem_pkg::*;
    localparam int HALF_NS = 50;
    logic       core_clk;
    logic       rst_n;
    logic       clk_en;
    logic       req_valid;
    logic       req_ready;
    logic [7:0] req_byte;
    logic       req_last;
    logic       idle_high;
    logic       pause_req;
    logic       lock_level;
    logic [7:0] rsp_byte;
    logic       rsp_valid;
    logic       active_power;
    logic       write_busy;
    logic [7:0] status_out;
    logic [7:0] rx_q [$];
    logic       oe_seen;
    logic       busy_seen;
    int         error_cnt;
    int         n_tests;

    spi_mem_if link ();
    spi_mem_master spi_mem_master_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link.master),
        .req_valid(req_valid), .req_ready(req_ready), .req_byte(req_byte),
        .req_last(req_last), .idle_high(idle_high), .pause_req(pause_req),
        .lock_level(lock_level), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid));
    spi_mem_device spi_mem_device_i (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .link(link.device),
        .active_power(active_power), .write_busy(write_busy), .status_out(status_out));
    spi_link_assertions spi_link_assertions_i (
        .core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk), .mosi(link.mosi),
        .miso(link.miso), .miso_oe(link.miso_oe), .cs_n(link.cs_n),
        .hold_n(link.hold_n), .wp_n(link.wp_n));

    initial begin
        core_clk = 1'b0;
        forever #HALF_NS core_clk = ~core_clk;
    end

    // collect received bytes and note any drive of the data-out line
    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) rx_q.push_back(rsp_byte);
        if (link.miso_oe === 1'b1) oe_seen = 1'b1;
        if (write_busy === 1'b1) busy_seen = 1'b1;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // one frame of n bytes; valid stays up between bytes so the frame is not broken
    task automatic xfer(input int n, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                        input logic [7:0] b2 = 8'h00, input logic [7:0] b3 = 8'h00);
        logic [7:0] b [4];
        int         wait_cnt;
        b = '{b0, b1, b2, b3};
        rx_q.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            req_valid = 1'b1;
            req_byte  = b[i];
            req_last  = (i == n - 1);
            wait_cnt  = 0;
            while (req_ready !== 1'b1 && wait_cnt < 400) begin
                @(negedge core_clk);
                wait_cnt++;
            end
            @(posedge core_clk);
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        wait_cnt  = 0;
        while ((rx_q.size() < n || link.cs_n !== 1'b1) && wait_cnt < 2000) begin
            @(negedge core_clk);
            wait_cnt++;
        end
        chk8("bytes in frame", 8'(n), 8'(rx_q.size()));
        repeat (8) @(negedge core_clk);
        chk8("standby after frame", 8'h00, {7'h00, active_power});
    endtask : xfer

    // status read, then write and read back the top two bytes of the array
    task automatic scen_write_read(input logic mode);
        logic [7:0] d0;
        d0 = mode ? 8'h3C : 8'hA5;
        idle_high = mode;
        xfer(1, OP_WREN);
        xfer(2, OP_RDSR);
        chk8("status read", 8'h02, rx_q[1]);
        busy_seen = 1'b0;
        xfer(4, OP_WRITE, 8'h07, 8'hFE, d0);
        chk8("busy during write", 8'h01, {7'h00, busy_seen});
        // a completed write drops write enable, so re-arm before the next one
        xfer(1, OP_WREN);
        xfer(4, OP_WRITE, 8'h07, 8'hFF, ~d0);
        xfer(4, OP_READ, 8'h07, 8'hFE);
        chk8("read low byte", d0, rx_q[3]);
        xfer(4, OP_READ, 8'h07, 8'hFF);
        chk8("read top byte", ~d0, rx_q[3]);
        chk8("idle clock level", {7'h00, mode}, {7'h00, link.sclk});
    endtask : scen_write_read

    // an unknown opcode must silence the device for the rest of the frame
    task automatic scen_unknown_op;
        oe_seen = 1'b0;
        xfer(4, 8'hFF, OP_READ, 8'h07, 8'hFE);
        chk8("drive after bad opcode", 8'h00, {7'h00, oe_seen});
        xfer(4, OP_READ, 8'h07, 8'hFE);
        chk8("read after bad opcode", 8'h3C, rx_q[3]);
    endtask : scen_unknown_op

    // pause in the middle of the data byte, then resume without losing place
    task automatic scen_pause;
        int wait_cnt;
        // empty the queue first so the pause branch cannot see the last frame's bytes
        rx_q.delete();
        fork
            xfer(4, OP_READ, 8'h07, 8'hFE);
            begin
                wait_cnt = 0;
                while (rx_q.size() < 3 && wait_cnt < 2000) begin
                    @(negedge core_clk);
                    wait_cnt++;
                end
                repeat (23) @(negedge core_clk);
                pause_req = 1'b1;
                repeat (60) @(negedge core_clk);
                chk8("drive during pause", 8'h00, {7'h00, link.miso_oe});
                chk8("power during pause", 8'h01, {7'h00, active_power});
                pause_req = 1'b0;
            end
        join
        chk8("read across pause", 8'h3C, rx_q[3]);
    endtask : scen_pause

    // protect bits follow status writes only while the lock pin is released
    task automatic scen_lock;
        xfer(1, OP_WREN);
        xfer(2, OP_WRSR, SR_PROT_MASK);
        chk8("protect set", SR_PROT_MASK, status_out & SR_PROT_MASK);
        lock_level = 1'b0;
        xfer(1, OP_WREN);
        xfer(2, OP_WRSR, 8'h00);
        chk8("protect frozen", SR_PROT_MASK, status_out & SR_PROT_MASK);
        lock_level = 1'b1;
        xfer(1, OP_WREN);
        xfer(2, OP_WRSR, 8'h00);
        chk8("protect cleared", 8'h00, status_out & SR_PROT_MASK);
    endtask : scen_lock

    initial begin
        rst_n      = 1'b0;
        clk_en     = 1'b1;
        req_valid  = 1'b0;
        req_byte   = 8'h00;
        req_last   = 1'b0;
        idle_high  = 1'b0;
        pause_req  = 1'b0;
        lock_level = 1'b1;
        oe_seen    = 1'b0;
        busy_seen  = 1'b0;
        error_cnt  = 0;
        n_tests    = 0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        scen_write_read(1'b0);
        scen_write_read(1'b1);
        scen_unknown_op();
        scen_pause();
        scen_lock();
        close_out();
    end

    // cut a hang short well past the expected run of about 5500 cycles
    initial begin
        #(HALF_NS * 2 * 40000);
        error_cnt++;
        close_out();
    end
endmodule : spi_eeprom_serial_front_end_test
